// [hdl/ofra_flash_access.v]
`timescale 1ns/100ps
`include "ofra_map.vh"

module ofra_flash_access (
  input  wire                      clk_sys_in,
  input  wire                      sys_rst_in,
  input  wire                      mode_pin_high_in,
  input  wire                      mode_pin_low_in,
  input  wire                      boot_select_pin_a_in,
  input  wire                      boot_select_pin_b_in,
  input  wire                      boot_select_pin_c_in,
  input  wire                      serial_rx_pin_in,
  input  wire                      boot_tx_data_in,
  input  wire                      rd_req_in,
  input  wire                      rd_word_in,
  input  wire [`OFRA_AW-1:0]       rd_addr_in,
  input  wire                      mode_control_register_rd_in,
  input  wire                      mode_control_register_wr_in,
  input  wire                      mode_control_register_wr_expanded_mode_enable_bit_in,
  input  wire                      flash_register_select_bit_in,
  input  wire                      op_req_in,
  input  wire [4:0]                op_sel_in,
  input  wire [`OFRA_AW-1:0]       op_addr_in,
  input  wire [`OFRA_NBLK-1:0]     erase_block_in,
  input  wire                      sw_protect_in,
  input  wire                      hw_protect_in,
  input  wire                      writer_pgm_en_in,
  output reg  [15:0]               rd_data_out,
  output reg                       rd_done_out,
  output reg                       rd_external_out,
  output reg                       rd_misaligned_out,
  output reg  [7:0]                mode_control_register_rdata_out,
  output reg                       rom_enabled_out,
  output reg  [`OFRA_MODE_W-1:0]   op_mode_out,
  output reg                       serial_tx_pin_out,
  output reg  [`OFRA_BAUD_W-1:0]   bit_time_out,
  output reg                       bit_time_valid_out,
  output reg  [4:0]                op_active_out,
  output reg                       op_done_out,
  output reg                       op_refused_out,
  output reg                       error_protect_out,
  output reg                       page_wr_out,
  output reg  [`OFRA_AW-1:0]       page_base_out,
  output reg                       block_erase_out,
  output reg  [`OFRA_NBLK-1:0]     block_sel_out
);

  // Flash array (60 kbytes as 30k half-words)
  reg  [15:0] flash_mem [0:30719];

  // Pin synchronisers
  reg  [5:0] pin_s1_reg;
  reg  [5:0] pin_s2_reg;
  reg  [5:0] mode_next;
  reg  [`OFRA_MODE_W-1:0] mode_reg;
  reg        expanded_mode_enable_bit_reg;
  reg        user_pgm_reg;
  reg        rd_stage_reg;
  reg [`OFRA_AW-1:0] rd_addr_reg;
  reg        rd_word_reg;
  reg        rx_d_reg;
  reg [`OFRA_BAUD_W-1:0] baud_cnt_reg;
  reg        baud_run_reg;
  reg [4:0]  op_reg;
  wire       rx_sync;
  wire       md_hi;
  wire       md_lo;
  wire       rom_map;
  wire       pgm_allowed;
  wire       op_legal;
  integer    idx;

  assign md_hi   = pin_s2_reg[0];
  assign md_lo   = pin_s2_reg[1];
  assign rx_sync = pin_s2_reg[5];

  // Single-bit set test shared by operation and block checks
  function one_hot8;
    input [7:0] v;
    begin
      one_hot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    end
  endfunction

  // ROM mapped from mode and expanded bit
  assign rom_map = (mode_reg == `OFRA_MODE_EXP_ROM) ||
                   ((mode_reg == `OFRA_MODE_SINGLE) && !expanded_mode_enable_bit_reg) ||
                   (mode_reg == `OFRA_MODE_BOOT) ||
                   (mode_reg == `OFRA_MODE_WRITER);

  assign pgm_allowed = (mode_reg == `OFRA_MODE_BOOT) || user_pgm_reg ||
                       ((mode_reg == `OFRA_MODE_WRITER) && writer_pgm_en_in);

  assign op_legal = one_hot8({4'h0, op_sel_in[4:1]}) && !op_sel_in[0];

  // Decode of synchronised mode pins
  always @* begin
    case ({md_hi, md_lo})
      2'b01:   mode_next = `OFRA_MODE_EXP_NROM;
      2'b10:   mode_next = `OFRA_MODE_EXP_ROM;
      2'b11:   mode_next = `OFRA_MODE_SINGLE;
      default: begin
        if ({pin_s2_reg[4], pin_s2_reg[3], pin_s2_reg[2]} == `OFRA_BSEL_BOOT)
          mode_next = `OFRA_MODE_BOOT;
        else
          mode_next = `OFRA_MODE_WRITER;
      end
    endcase
  end

  // Synchronisers and mode capture during reset
  always @(posedge clk_sys_in) begin
    pin_s1_reg <= {serial_rx_pin_in, boot_select_pin_c_in, boot_select_pin_b_in,
                   boot_select_pin_a_in, mode_pin_low_in, mode_pin_high_in};
    pin_s2_reg <= pin_s1_reg;
    if (sys_rst_in) begin
      mode_reg     <= mode_next;
      user_pgm_reg <= ({pin_s2_reg[4], pin_s2_reg[3], pin_s2_reg[2]} ==
                       `OFRA_BSEL_USERPGM) && !md_hi && !md_lo;
      expanded_mode_enable_bit_reg     <= (mode_next == `OFRA_MODE_EXP_NROM);
    end else if (mode_control_register_wr_in && (mode_reg == `OFRA_MODE_BOOT)) begin
      expanded_mode_enable_bit_reg <= mode_control_register_wr_expanded_mode_enable_bit_in;
    end
  end

  // Mode control register read, register bits latched on read; ROM enable and mode outputs updated every cycle
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mode_control_register_rdata_out  <= `OFRA_MODE_CONTROL_REGISTER_RSVD;
      rom_enabled_out <= 1'b0;
      op_mode_out     <= `OFRA_MODE_NONE;
    end else begin
      if (mode_control_register_rd_in)
        mode_control_register_rdata_out <= `OFRA_MODE_CONTROL_REGISTER_RSVD | {expanded_mode_enable_bit_reg, 5'h00, md_hi, md_lo};
      rom_enabled_out <= rom_map;
      op_mode_out     <= mode_reg;
    end
  end

  // Two-state read: capture then drive lanes
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rd_stage_reg      <= 1'b0;
      rd_addr_reg       <= 16'h0000;
      rd_word_reg       <= 1'b0;
      rd_done_out       <= 1'b0;
      rd_data_out       <= 16'h0000;
      rd_external_out   <= 1'b0;
      rd_misaligned_out <= 1'b0;
    end else begin
      rd_done_out       <= 1'b0;
      rd_external_out   <= 1'b0;
      rd_misaligned_out <= 1'b0;
      if (rd_req_in && !rd_stage_reg) begin
        rd_stage_reg <= 1'b1;
        rd_addr_reg  <= rd_addr_in;
        rd_word_reg  <= rd_word_in;
      end else if (rd_stage_reg) begin
        rd_stage_reg <= 1'b0;
        rd_done_out  <= 1'b1;
        if (!rom_map || (rd_addr_reg > `OFRA_ROM_TOP)) begin
          rd_external_out <= 1'b1;
          rd_data_out     <= 16'h0000;
        end else if (rd_word_reg && rd_addr_reg[0]) begin
          rd_misaligned_out <= 1'b1;
          rd_data_out       <= 16'h0000;
        end else if (rd_word_reg) begin
          rd_data_out <= flash_mem[rd_addr_reg[15:1]];
        end else if (!rd_addr_reg[0]) begin
          rd_data_out <= {flash_mem[rd_addr_reg[15:1]][15:8], 8'h00};
        end else begin
          rd_data_out <= {8'h00, flash_mem[rd_addr_reg[15:1]][7:0]};
        end
      end
    end
  end

  // Array operations with protection
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      op_reg            <= `OFRA_OP_IDLE;
      op_active_out     <= `OFRA_OP_IDLE;
      op_done_out       <= 1'b0;
      op_refused_out    <= 1'b0;
      error_protect_out <= 1'b0;
      page_wr_out       <= 1'b0;
      page_base_out     <= 16'h0000;
      block_erase_out   <= 1'b0;
      block_sel_out     <= 8'h00;
    end else begin
      op_done_out     <= 1'b0;
      op_refused_out  <= 1'b0;
      page_wr_out     <= 1'b0;
      block_erase_out <= 1'b0;
      op_active_out   <= op_reg;
      if (op_req_in && !flash_register_select_bit_in) begin
        op_refused_out <= 1'b1;
      end else if (op_req_in) begin
        if (!op_legal || ((op_sel_in == `OFRA_OP_ERASE) && !one_hot8(erase_block_in)))
          error_protect_out <= 1'b1;
        if (hw_protect_in || sw_protect_in || error_protect_out || !pgm_allowed ||
            !op_legal || ((op_sel_in == `OFRA_OP_ERASE) && !one_hot8(erase_block_in))) begin
          op_refused_out <= 1'b1;
        end else begin
          op_reg      <= op_sel_in;
          op_done_out <= 1'b1;
          if (op_sel_in == `OFRA_OP_PROG) begin
            page_wr_out   <= 1'b1;
            page_base_out <= {op_addr_in[15:5], 5'h00};
          end
          if (op_sel_in == `OFRA_OP_ERASE) begin
            block_erase_out <= 1'b1;
            block_sel_out   <= erase_block_in;
          end
        end
      end
    end
  end

  // Boot-mode serial bit-time measurement and tx pass-through (tx held high in other modes)
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx_d_reg           <= 1'b1;
      baud_cnt_reg       <= 16'h0000;
      baud_run_reg       <= 1'b0;
      bit_time_out       <= `OFRA_BAUD_MIN;
      bit_time_valid_out <= 1'b0;
      serial_tx_pin_out  <= 1'b1;
    end else begin
      rx_d_reg          <= rx_sync;
      serial_tx_pin_out <= (mode_reg == `OFRA_MODE_BOOT) ? boot_tx_data_in : 1'b1;
      if ((mode_reg == `OFRA_MODE_BOOT) && !bit_time_valid_out) begin
        if (rx_d_reg && !rx_sync) begin
          baud_run_reg <= 1'b1;
          baud_cnt_reg <= `OFRA_BAUD_MIN;
        end else if (baud_run_reg && !rx_d_reg && rx_sync) begin
          baud_run_reg       <= 1'b0;
          bit_time_out       <= baud_cnt_reg;
          bit_time_valid_out <= 1'b1;
        end else if (baud_run_reg) begin
          baud_cnt_reg <= baud_cnt_reg + `OFRA_BAUD_MIN;
        end
      end
    end
  end

  // Functional array update
  always @(posedge clk_sys_in) begin
    if (page_wr_out) begin
      for (idx = 0; idx < `OFRA_PAGE_BYTES / 2; idx = idx + 1)
        flash_mem[page_base_out[15:1] + idx[14:0]] <= 16'h0000;
    end
  end

endmodule // ofra_flash_access

// [shared/ofra_map.vh]
`ifndef OFRA_MAP_VH
`define OFRA_MAP_VH

// Operating mode codes (one-hot)
`define OFRA_MODE_W        6
`define OFRA_MODE_NONE     6'h01
`define OFRA_MODE_EXP_NROM 6'h02
`define OFRA_MODE_EXP_ROM  6'h04
`define OFRA_MODE_SINGLE   6'h08
`define OFRA_MODE_BOOT     6'h10
`define OFRA_MODE_WRITER   6'h20

// Boot-select pin codes when both mode pins are low
`define OFRA_BSEL_BOOT     3'h0
`define OFRA_BSEL_USERPGM  3'h1

// Array operations (one-hot)
`define OFRA_OP_IDLE       5'h01
`define OFRA_OP_PROG       5'h02
`define OFRA_OP_PVER       5'h04
`define OFRA_OP_ERASE      5'h08
`define OFRA_OP_EVER       5'h10

// Geometry
`define OFRA_AW            16
`define OFRA_ROM_TOP       16'hefff
`define OFRA_PAGE_BYTES    32
`define OFRA_PAGE_AW       5
`define OFRA_NBLK          8

// Block starts: four 1k, 2k, 12k, 16k, 26k
`define OFRA_BLK1          16'h0400
`define OFRA_BLK2          16'h0800
`define OFRA_BLK3          16'h0c00
`define OFRA_BLK4          16'h1000
`define OFRA_BLK5          16'h1800
`define OFRA_BLK6          16'h4800
`define OFRA_BLK7          16'h8800

// Bit-rate measurement
`define OFRA_BAUD_W        16
`define OFRA_BAUD_MIN      16'h0001

// Mode control register reserved bits and erased byte value
`define OFRA_MODE_CONTROL_REGISTER_RSVD     8'h64
`define OFRA_ERASED_BYTE   8'hff

`endif

// [tb/ofra_flash_access_properties.sv]
`timescale 1ns/100ps
module ofra_flash_access_properties (
  input logic        clk_sys_in,
  input logic        sys_rst_in,
  input logic        rd_req_in,
  input logic        rd_done_out,
  input logic        rd_external_out,
  input logic        rom_enabled_out,
  input logic        op_req_in,
  input logic        flash_register_select_bit_in,
  input logic        hw_protect_in,
  input logic        op_done_out,
  input logic        op_refused_out,
  input logic        mode_control_register_rd_in,
  input logic [7:0]  mode_control_register_rdata_out,
  input logic [5:0]  op_mode_out,
  input logic        page_wr_out,
  input logic [15:0] page_base_out,
  input logic        block_erase_out,
  input logic [7:0]  block_sel_out,
  input logic        error_protect_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // Read timing and routing
  AST_RD_TWO:
    assert property (rd_req_in |-> ##2 rd_done_out) else $error("read late");
  AST_RD_EXT:
    assert property (rd_req_in && !rom_enabled_out |-> ##2 rd_external_out) else $error("not ext");
  // Operation answers, mode hold and mode control register bits
  AST_OP_ANS:
    assert property (op_req_in |=> op_done_out != op_refused_out) else $error("op answer");
  AST_SEL_OFF:
    assert property (op_req_in && !flash_register_select_bit_in |=> op_refused_out)
      else $error("select");
  AST_HW_PROT:
    assert property (op_req_in && hw_protect_in |=> op_refused_out) else $error("protect");
  AST_MODE_HOLD:
    assert property (!$past(sys_rst_in) && !$past(sys_rst_in, 2) |-> $stable(op_mode_out))
      else $error("mode moved");
  AST_MODE_CONTROL_REGISTER_FIX:
    assert property (mode_control_register_rd_in |=> mode_control_register_rdata_out[6:2] == 5'h19) else $error("mode_control_register bits");
  AST_PAGE:
    assert property (page_wr_out |-> op_done_out && page_base_out[4:0] == 5'h00)
      else $error("page base");
  AST_BLK:
    assert property (block_erase_out |-> op_done_out && $onehot(block_sel_out))
      else $error("block sel");
  AST_ERR_PROT:
    assert property (op_req_in && error_protect_out |=> op_refused_out)
      else $error("error protect");
endmodule // ofra_flash_access_properties

bind ofra_flash_access ofra_flash_access_properties chk_u (.clk_sys_in, .sys_rst_in,
  .rd_req_in, .rd_done_out, .rd_external_out, .rom_enabled_out, .op_req_in,
  .flash_register_select_bit_in, .hw_protect_in, .op_done_out, .op_refused_out,
  .mode_control_register_rd_in, .mode_control_register_rdata_out, .op_mode_out, .page_wr_out, .page_base_out,
  .block_erase_out, .block_sel_out, .error_protect_out);

// [tb/ofra_cpu_model.sv]
`timescale 1ns/100ps
module ofra_cpu_model (
  input  logic        clk_sys_in,
  input  logic        sys_rst_in,
  input  logic        go_in,
  input  logic        word_in,
  input  logic [15:0] addr_in,
  input  logic        rd_done_in,
  output logic        rd_req_out = 1'b0,
  output logic        rd_word_out = 1'b0,
  output logic [15:0] rd_addr_out = 16'h0000
);
  logic busy_reg = 1'b0;
  // One read at a time; address held until the answer, then scrambled
  always @(posedge clk_sys_in) begin
    rd_req_out <= 1'b0;
    if (sys_rst_in) begin
      busy_reg <= 1'b0;
    end else if (go_in && !busy_reg) begin
      busy_reg    <= 1'b1;
      rd_req_out  <= 1'b1;
      rd_word_out <= word_in;
      rd_addr_out <= {addr_in[15:1], addr_in[0] & !word_in};
    end else if (busy_reg && rd_done_in) begin
      busy_reg    <= 1'b0;
      rd_addr_out <= ~rd_addr_out;
    end
  end
endmodule // ofra_cpu_model

// [tb/tb_ofra_flash_access.sv]
`timescale 1ns/100ps
`include "ofra_map.vh"
module tb_ofra_flash_access;
  logic clk = 1'b0, rst = 1'b1, hi = 1'b0, lo = 1'b0, go = 1'b0, word = 1'b0, rx = 1'b1;
  logic mrd = 1'b0, mwr = 1'b0, fsel = 1'b1, oreq = 1'b0, swp = 1'b0, hwp = 1'b0, txd = 1'b1;
  logic [2:0] bsel = 3'h0;
  logic [4:0] osel = 5'h02;
  logic [15:0] addr = 16'h0000, oaddr = 16'h0000, raddr, pbase, bt, rdat;
  logic [7:0] blk = 8'h01, mode_control_register, bsl;
  logic [5:0] mode;
  logic [4:0] oact;
  logic rreq, rword, done, ext, odone, oref, pwr, berase, rom_en, tx, btv, mis, eprot;
  logic wexpe = 1'b1, wpe = 1'b1;
  int errors = 0, num_checks = 0, cyc = 0;
  initial forever #12.5 clk = ~clk;
  ofra_cpu_model cpu_u (.clk_sys_in(clk), .sys_rst_in(rst), .go_in(go), .word_in(word),
    .addr_in(addr), .rd_done_in(done), .rd_req_out(rreq), .rd_word_out(rword),
    .rd_addr_out(raddr));
  ofra_flash_access dut_u (.clk_sys_in(clk), .sys_rst_in(rst), .mode_pin_high_in(hi),
    .mode_pin_low_in(lo), .boot_select_pin_a_in(bsel[0]), .boot_select_pin_b_in(bsel[1]),
    .boot_select_pin_c_in(bsel[2]), .serial_rx_pin_in(rx), .boot_tx_data_in(txd),
    .rd_req_in(rreq), .rd_word_in(rword), .rd_addr_in(raddr), .mode_control_register_rd_in(mrd),
    .mode_control_register_wr_in(mwr), .mode_control_register_wr_expanded_mode_enable_bit_in(wexpe), .flash_register_select_bit_in(fsel),
    .op_req_in(oreq), .op_sel_in(osel), .op_addr_in(oaddr), .erase_block_in(blk),
    .sw_protect_in(swp), .hw_protect_in(hwp), .writer_pgm_en_in(wpe), .rd_data_out(rdat),
    .rd_done_out(done), .rd_external_out(ext), .rd_misaligned_out(mis),
    .mode_control_register_rdata_out(mode_control_register),
    .rom_enabled_out(rom_en), .op_mode_out(mode), .serial_tx_pin_out(tx), .bit_time_out(bt),
    .bit_time_valid_out(btv), .op_active_out(oact), .op_done_out(odone),
    .op_refused_out(oref),
    .error_protect_out(eprot), .page_wr_out(pwr), .page_base_out(pbase),
    .block_erase_out(berase), .block_sel_out(bsl));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected mode from pins held in reset
  function automatic logic [5:0] exp_mode(input logic [1:0] p, input logic [2:0] b);
    if (p == 2'b01) return `OFRA_MODE_EXP_NROM;
    if (p == 2'b10) return `OFRA_MODE_EXP_ROM;
    if (p == 2'b11) return `OFRA_MODE_SINGLE;
    return (b == `OFRA_BSEL_BOOT) ? `OFRA_MODE_BOOT : `OFRA_MODE_WRITER;
  endfunction
  // One-cycle pulse request, answer read at the edge after the taking edge
  task automatic op(input logic [4:0] s, input logic ok);
    oaddr <= 16'($urandom % 16'hf000);
    blk   <= 8'h01 << ($urandom % 8);
    osel  <= s;
    oreq  <= 1'b1;
    @(posedge clk);
    oreq <= 1'b0;
    @(posedge clk);
    check({odone, oref}, {ok, !ok});
    if (ok && s == `OFRA_OP_PROG) check({pwr, pbase}, {1'b1, oaddr & 16'hffe0});
    if (ok && s == `OFRA_OP_ERASE) check({berase, bsl}, {1'b1, blk});
    if (ok) begin
      @(posedge clk);
      check(oact, s);
    end
  endtask
  // CPU read through the partner, answer waited for under a bound
  task automatic rd(input logic exp_ext);
    addr <= 16'($urandom % 16'hf000);
    word <= 1'($urandom);
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    check({done, ext, mis}, {1'b1, exp_ext, 1'b0});
    if (!exp_ext && !rword) check(raddr[0] ? rdat[15:8] : rdat[7:0], 8'h00);
  endtask
  // Run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  // Main sequence: one reset per pin setting, three of them with both mode pins low and boot-select 0, 1, 2
  initial begin
    logic [1:0] p;
    logic [2:0] b;
    void'($urandom(4));
    for (int i = 0; i < 6; i++) begin
      p = (i < 3) ? 2'(i + 1) : 2'b00;
      b = (i < 3) ? 3'h0 : 3'(i - 3);
      @(posedge clk);
      rst  <= 1'b1;
      {hi, lo} <= p;
      bsel <= b;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      check(mode, exp_mode(p, b));
      wexpe <= 1'($urandom);
      mwr   <= 1'b1;
      @(posedge clk);
      mwr <= 1'b0;
      mrd <= 1'b1;
      @(posedge clk);
      mrd <= 1'b0;
      @(posedge clk);
      check(mode_control_register, {p == 2'b01 || (p == 2'b00 && b == 3'h0 && wexpe), 5'h19, p});
      if (p != 2'b00) begin
        check(rom_en, p != 2'b01);
        rd(p == 2'b01);
        op(`OFRA_OP_PROG, 1'b0);
      end
      if (i == 3) begin
        txd <= 1'b0;
        rx  <= 1'b0;
        repeat (9) @(posedge clk);
        rx <= 1'b1;
        repeat (6) @(posedge clk);
        check({btv, bt}, {1'b1, 16'd9});
        check(tx, 1'b0);
      end
      if (i == 4) begin
        fsel <= 1'b0;
        op(`OFRA_OP_PROG, 1'b0);
        fsel <= 1'b1;
        hwp  <= 1'b1;
        op(`OFRA_OP_ERASE, 1'b0);
        hwp <= 1'b0;
        swp <= 1'b1;
        op(`OFRA_OP_PVER, 1'b0);
        swp <= 1'b0;
        for (int k = 0; k < 4; k++) op(5'h02 << k, 1'b1);
        repeat (8) op(`OFRA_OP_ERASE, 1'b1);
        op(5'h03, 1'b0);
        check(eprot, 1'b1);
        op(`OFRA_OP_PROG, 1'b0);
      end
      if (i == 5) begin
        wpe <= 1'b0;
        op(`OFRA_OP_PROG, 1'b0);
        wpe <= 1'b1;
        op(`OFRA_OP_PROG, 1'b1);
      end
      // Pins moved after reset must not move the mode
      {hi, lo} <= ~p;
      repeat (4) @(posedge clk);
      check(mode, exp_mode(p, b));
    end
    end_of_test();
  end
endmodule // tb_ofra_flash_access
